// ==== hbp_pkg.sv ====
// Package of constants and types for the half-bridge PWM dead-time timing block
package hbp_pkg;

  // Width of the cycle counters and delay settings
  localparam int unsigned CW = 16;

  // System clock period
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Main clock pulse width, delay offsets and the floor on the delayed clock
  localparam int unsigned T_CLK_NS     = 65;
  localparam int unsigned TD_OFFSET_NS = 20;
  localparam int unsigned TD_MIN_NS    = 30;
  localparam int unsigned T2_OFFSET_NS = 30;

  // Cycle counts derived from the times; least times round up
  localparam logic [CW-1:0] CLK_HI_CYC  = CW'((T_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CW-1:0] TD_OFF_CYC  = CW'((TD_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CW-1:0] TD_MIN_CYC  = CW'((TD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CW-1:0] T2_OFF_CYC  = CW'((T2_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Default oscillator period in system cycles (one half switching period)
  localparam int unsigned OSC_CYC_DEF = 50;

  // Reset values
  localparam logic [CW-1:0] CNT_RST = 16'h0000;

  // Phase encoding: which primary drive owns the current oscillator period
  localparam logic PH_LOW  = 1'b0;
  localparam logic PH_HIGH = 1'b1;

  // Four drive outputs travel together
  typedef struct packed {
    logic low_primary_drive;
    logic high_primary_drive;
    logic rectifier_drive_a;
    logic rectifier_drive_b;
  } hbp_drive_t;

  localparam hbp_drive_t DRIVE_RST = '{default: 1'b0};

  // Primary drive sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FREE,
    ST_WAIT_ON,
    ST_DRIVE,
    ST_DEAD2
  } hbp_state_t;

endpackage

// ==== hbp_timing.sv ====
// Half-bridge PWM timing: oscillator phases, dead-times and four drive outputs
// What this block does
// - Alternate phases, low first, each then freewheel unless the next period starts first
// - Freewheel holds both primary drives inactive
// - Delayed clock equals first setting plus offset
// - Main clock rise turns off leaving rectifier
// - Primary turns on at delayed clock fall
// - Main clock pulse 65 ns rounded up to two cycles, 100 ns wide
// - Delayed clock delay never below 30 ns
// - Primary ends on ramp or delayed rise
// - Second dead-time before rectifier re-asserts
// - Low drive on: rectifier b on, a off
// - Freewheel holds both rectifier drives on
// - Rectifier b off before high drive on
// - After high drive, dead-time, both rectifiers on
// - Main clock high blanks turn-on of both primary drives
// - Oscillator runs at twice switching frequency
`timescale 1ns/10ps
`default_nettype none
module hbp_timing #(
  parameter int unsigned OSC_CYC = hbp_pkg::OSC_CYC_DEF
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Control and comparator, asynchronous to i_clk
  input  wire logic                   i_enable,
  input  wire logic                   i_ramp_above,
  // Dead-time settings in extra cycles, sampled while idle
  input  wire logic [hbp_pkg::CW-1:0] i_first_delay_setting,
  input  wire logic [hbp_pkg::CW-1:0] i_second_delay_setting,
  // Drive outputs and timing clocks
  output var  hbp_pkg::hbp_drive_t    o_drive,
  output logic                        o_main_clk,
  output logic                        o_delayed_clk
);
  import hbp_pkg::*;

  localparam logic [CW-1:0] OSC_LAST = CW'(OSC_CYC - 1);

  // Two-flop synchronisers; the first stage feeds only the second
  logic en_m_r;
  logic en_s_r;
  logic ramp_m_r;
  logic ramp_s_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_m_r   <= 1'b0;
      en_s_r   <= 1'b0;
      ramp_m_r <= 1'b0;
      ramp_s_r <= 1'b0;
    end else begin
      en_m_r   <= i_enable;
      en_s_r   <= en_m_r;
      ramp_m_r <= i_ramp_above;
      ramp_s_r <= ramp_m_r;
    end
  end

  // Sequencer state
  hbp_state_t  state_r, state_nxt;
  logic [CW-1:0] pos_r, pos_nxt;
  logic [CW-1:0] td_r, td_nxt;
  logic [CW-1:0] t2_r, t2_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          phase_r, phase_nxt;
  logic          drv_hi_r, drv_hi_nxt;
  logic          go_r, go_nxt;
  hbp_drive_t    drive_r, drive_nxt;
  logic          mclk_r, mclk_nxt;
  logic          dclk_r, dclk_nxt;
  logic [CW-1:0] td_raw;
  logic [CW-1:0] t2_raw;
  logic [CW-1:0] on_pos;

  // The delayed clock falls one pulse width after it rises
  assign on_pos = td_r + CLK_HI_CYC;
  assign td_raw = i_first_delay_setting + TD_OFF_CYC;
  assign t2_raw = i_second_delay_setting + T2_OFF_CYC;

  // Next-state logic; the rectifier return runs on its own counter, and a long
  // second dead-time holds off the following phase's turn-on until the count ends
  always_comb begin
    state_nxt  = state_r;
    pos_nxt    = pos_r;
    td_nxt     = td_r;
    t2_nxt     = t2_r;
    cnt_nxt    = cnt_r;
    phase_nxt  = phase_r;
    drv_hi_nxt = drv_hi_r;
    go_nxt     = go_r;
    drive_nxt  = drive_r;
    if (!en_s_r) begin
      state_nxt = ST_IDLE;
      drive_nxt = DRIVE_RST;
      pos_nxt   = CNT_RST;
      go_nxt    = 1'b0;
      cnt_nxt   = CNT_RST; // A pending return must not survive a stop
      // Settings only load while switching is stopped; a wrapped sum is floored
      td_nxt    = (td_raw < TD_MIN_CYC) ? TD_MIN_CYC : td_raw;
      t2_nxt    = (t2_raw < T2_OFF_CYC) ? T2_OFF_CYC : t2_raw;
    end else if (state_r == ST_IDLE) begin
      state_nxt = ST_FREE;
      pos_nxt   = CNT_RST;
      phase_nxt = PH_LOW;
      drive_nxt.rectifier_drive_a = 1'b1;
      drive_nxt.rectifier_drive_b = 1'b1;
    end else begin
      // Oscillator: each primary owns every other period
      pos_nxt = (pos_r == OSC_LAST) ? CNT_RST : pos_r + 16'h0001;
      if (pos_r == OSC_LAST) begin
        phase_nxt = ~phase_r;
      end
      // Main clock rise: drop the rectifier that opposes the coming phase;
      // while the previous primary still runs at max duty, its end does it
      if (pos_r == CNT_RST) begin
        if (phase_r == PH_LOW) begin
          if (!drive_r.high_primary_drive) begin
            drive_nxt.rectifier_drive_a = 1'b0;
          end
        end else if (!drive_r.low_primary_drive) begin
          drive_nxt.rectifier_drive_b = 1'b0;
        end
      end
      // Second dead-time: the ended phase's rectifier returns at count end
      if (cnt_r != CNT_RST) begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          if (drv_hi_r == PH_LOW) begin
            drive_nxt.rectifier_drive_a = 1'b1;
          end else begin
            drive_nxt.rectifier_drive_b = 1'b1;
          end
        end
      end
      case (state_r)
        ST_FREE: begin
          // Both primaries stay off, both rectifiers on
          if (pos_r == CNT_RST) begin
            state_nxt = ST_WAIT_ON;
          end
        end
        ST_WAIT_ON: begin
          // Main clock high lies before on_pos, so it blanks both primaries;
          // turn-on waits while the in-phase rectifier is still in dead-time
          if (pos_r >= on_pos && cnt_r == CNT_RST) begin
            state_nxt  = ST_DRIVE;
            drv_hi_nxt = phase_r;
            if (phase_r == PH_LOW) begin
              drive_nxt.low_primary_drive = 1'b1;
            end else begin
              drive_nxt.high_primary_drive = 1'b1;
            end
          end
        end
        ST_DRIVE: begin
          if (pos_r == CNT_RST) begin
            go_nxt = 1'b1;
          end
          // Ramp crossing or next delayed clock rise, whichever first
          if (ramp_s_r || (go_r && pos_r == td_r)) begin
            cnt_nxt                      = t2_r;
            go_nxt                       = 1'b0;
            drive_nxt.low_primary_drive  = 1'b0;
            drive_nxt.high_primary_drive = 1'b0;
            if (go_r || pos_r == CNT_RST) begin
              // The next period already began: drop its opposing rectifier now
              state_nxt = ST_WAIT_ON;
              if (phase_r == PH_LOW) begin
                drive_nxt.rectifier_drive_a = 1'b0;
              end else begin
                drive_nxt.rectifier_drive_b = 1'b0;
              end
            end else begin
              state_nxt = ST_DEAD2;
            end
          end
        end
        ST_DEAD2: begin
          // Period start wins over the end of the dead-time
          if (pos_r == CNT_RST) begin
            state_nxt = ST_WAIT_ON;
          end else if (cnt_r == 16'h0001) begin
            state_nxt = ST_FREE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          drive_nxt = DRIVE_RST;
        end
      endcase
    end
    // Timing clocks for observation, one register behind the counter so their
    // edges land on the same clock edge as the drive edges that they time
    mclk_nxt = en_s_r && (state_r != ST_IDLE) && (pos_r < CLK_HI_CYC);
    dclk_nxt = en_s_r && (state_r != ST_IDLE) && (pos_r >= td_r) && (pos_r < on_pos);
  end

  // Registers of the sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= ST_IDLE;
      pos_r    <= CNT_RST;
      td_r     <= TD_MIN_CYC;
      t2_r     <= T2_OFF_CYC;
      cnt_r    <= CNT_RST;
      phase_r  <= PH_LOW;
      drv_hi_r <= PH_LOW;
      go_r     <= 1'b0;
      drive_r  <= DRIVE_RST;
      mclk_r   <= 1'b0;
      dclk_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      pos_r    <= pos_nxt;
      td_r     <= td_nxt;
      t2_r     <= t2_nxt;
      cnt_r    <= cnt_nxt;
      phase_r  <= phase_nxt;
      drv_hi_r <= drv_hi_nxt;
      go_r     <= go_nxt;
      drive_r  <= drive_nxt;
      mclk_r   <= mclk_nxt;
      dclk_r   <= dclk_nxt;
    end
  end

  assign o_drive       = drive_r;
  assign o_main_clk    = mclk_r;
  assign o_delayed_clk = dclk_r;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_no_overlap: assert property (!(drive_r.low_primary_drive && drive_r.high_primary_drive))
    else $error("both primary drives on");
  chk_free_prims: assert property (state_r == ST_FREE |->
    !drive_r.low_primary_drive && !drive_r.high_primary_drive)
    else $error("primary on while freewheeling");
  chk_free_rects: assert property (state_r == ST_FREE && en_s_r |->
    drive_r.rectifier_drive_a && drive_r.rectifier_drive_b)
    else $error("rectifier off while freewheeling");
  chk_low_rects: assert property (drive_r.low_primary_drive |->
    drive_r.rectifier_drive_b && !drive_r.rectifier_drive_a)
    else $error("wrong rectifiers during low drive");
  chk_high_rect_b: assert property ($rose(drive_r.high_primary_drive) |->
    !drive_r.rectifier_drive_b && $past(!drive_r.rectifier_drive_b))
    else $error("rectifier b still on at high drive");
  chk_td_floor: assert property (td_r >= TD_MIN_CYC)
    else $error("delayed clock delay below floor");
  chk_turn_on_pos: assert property ($rose(drive_r.low_primary_drive || drive_r.high_primary_drive) |->
    ($past(pos_r) == $past(on_pos) || ($past(pos_r) > $past(on_pos) && $past(cnt_r, 2) == 16'h0001)) &&
    !mclk_r)
    else $error("primary turned on off the delayed clock fall");
  chk_ramp_end: assert property (state_r == ST_DRIVE && ramp_s_r && en_s_r |=>
    !drive_r.low_primary_drive && !drive_r.high_primary_drive)
    else $error("primary not ended by ramp");
  chk_dead_rect: assert property ($rose(drive_r.rectifier_drive_a) && $past(state_r) != ST_IDLE |->
    $past(cnt_r) == 16'h0001 && $past(drv_hi_r) == PH_LOW)
    else $error("rectifier a returned before dead-time");
  chk_phase_flip: assert property (en_s_r && state_r != ST_IDLE && pos_r == OSC_LAST |=>
    phase_r != $past(phase_r))
    else $error("phase did not alternate");
  chk_cfg_hold: assert property (en_s_r && $past(en_s_r) |-> $stable(td_r) && $stable(t2_r))
    else $error("delay settings changed while running");

  cov_low_pulse: cover property ($fell(drive_r.low_primary_drive));
  cov_high_pulse: cover property ($fell(drive_r.high_primary_drive));
  cov_max_duty: cover property (state_r == ST_DRIVE && go_r && pos_r == td_r && !ramp_s_r);
  cov_free_both: cover property (state_r == ST_FREE && drive_r.rectifier_drive_a && drive_r.rectifier_drive_b);

endmodule
`default_nettype wire

// ==== hbp_far_model.sv ====
// Far-side model: gate drivers and isolator with a cross-conduction watch
`timescale 1ns/10ps
`default_nettype none
module hbp_far_model (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Drives from the block
  input  wire hbp_pkg::hbp_drive_t i_drive,
  // Gate levels past the isolator, sticky fault flag
  output var  hbp_pkg::hbp_drive_t o_gate,
  output var  logic                o_shoot
);
  import hbp_pkg::*;
  logic shoot_nxt;
  // Faults judged on the drives, since real isolators add skew per channel
  always_comb begin
    shoot_nxt = o_shoot;
    if (i_drive.low_primary_drive && (i_drive.high_primary_drive || i_drive.rectifier_drive_a)) begin
      shoot_nxt = 1'b1;
    end
    if (i_drive.high_primary_drive && i_drive.rectifier_drive_b) begin
      shoot_nxt = 1'b1;
    end
  end
  // One cycle of isolator delay
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gate  <= DRIVE_RST;
      o_shoot <= 1'b0;
    end else begin
      o_gate  <= i_drive;
      o_shoot <= shoot_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== hbp_timing_tb.sv ====
// Testbench for the half-bridge PWM timing block
`timescale 1ns/10ps
`default_nettype none
module hbp_timing_tb;
  import hbp_pkg::*;
  localparam int OSC = 20;
  localparam int TD  = 3; // First setting 2, plus one
  localparam int T2  = 4; // Second setting 3, plus one
  logic          i_clk, i_rst_n, i_enable, i_ramp_above, o_main_clk, o_delayed_clk, shoot;
  logic [CW-1:0] first_set, second_set;
  hbp_drive_t    o_drive;
  logic [5:0]    mon;
  int            n_fail, compares, n, a;
  // Bits: 5 main, 4 delayed, 3 low, 2 high, 1 rect a, 0 rect b
  assign mon = {o_main_clk, o_delayed_clk, o_drive};
  hbp_timing #(.OSC_CYC(OSC)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(i_enable),
    .i_ramp_above(i_ramp_above), .i_first_delay_setting(first_set), .i_second_delay_setting(second_set),
    .o_drive(o_drive), .o_main_clk(o_main_clk), .o_delayed_clk(o_delayed_clk));
  hbp_far_model far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_drive(o_drive), .o_gate(), .o_shoot(shoot));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_n(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %0d want %0d", $time, what, got, exp);
    end
  endtask
  task automatic chk_v(input logic [5:0] got, input logic [5:0] mask, input logic [5:0] exp, input string what);
    compares++;
    if ((got & mask) !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, got & mask, exp);
    end
  endtask
  // Bounded wait for one output bit; a hang ends the run
  task automatic wait_for(input int idx, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge i_clk);
      #1;
      cnt++;
    end while (mon[idx] !== v && cnt < 200);
    if (mon[idx] !== v) begin
      n_fail++;
      $display("[ERR] %0t wait on bit %0d timed out", $time, idx);
      close_out();
    end
  endtask
  task automatic t_low();
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    chk_v(mon, 6'h0f, 6'h01, "rect a off");
    wait_for(3, 1'b1, n);
    chk_n(n, TD + 2, "low on lag");
    chk_v(mon, 6'h0f, 6'h09, "low phase");
    @(posedge i_clk) i_ramp_above <= 1'b1;
    wait_for(3, 1'b0, n);
    chk_n(int'(n <= 4), 1, "ramp end");
    chk_v(mon, 6'h0f, 6'h01, "dead time");
    wait_for(1, 1'b1, n);
    chk_n(n, T2, "rect a return");
    chk_v(mon, 6'h0f, 6'h03, "freewheel");
    @(posedge i_clk) i_ramp_above <= 1'b0;
    $display("test low phase done");
  endtask
  task automatic t_high();
    wait_for(0, 1'b0, n);
    chk_v(mon, 6'h0f, 6'h02, "rect b off");
    wait_for(2, 1'b1, n);
    chk_n(n, TD + 2, "high on lag");
    chk_v(mon, 6'h0f, 6'h06, "high phase");
    wait_for(2, 1'b0, n);
    chk_n(n, OSC - 2, "max duty width");
    wait_for(0, 1'b1, n);
    chk_n(n, T2, "rect b return");
    $display("test high phase done");
  endtask
  task automatic t_clock();
    wait_for(5, 1'b0, n);
    wait_for(5, 1'b1, n);
    wait_for(5, 1'b0, n);
    chk_n(n, int'(CLK_HI_CYC), "clock pulse");
    wait_for(5, 1'b1, n);
    chk_n(n + 2, OSC, "clock period");
    wait_for(4, 1'b1, n);
    chk_n(n, TD, "delayed lag");
    $display("test clocks done");
  endtask
  // Shortest settings, ramp always above: one-cycle pulses keep the phases visible
  task automatic t_floor();
    @(posedge i_clk) i_enable <= 1'b0;
    first_set  <= 16'h0000;
    second_set <= 16'h0000;
    repeat (4) @(posedge i_clk);
    #1;
    chk_v(mon, 6'h0f, 6'h00, "disabled");
    @(posedge i_clk) i_enable <= 1'b1;
    i_ramp_above <= 1'b1;
    wait_for(5, 1'b1, n);
    wait_for(4, 1'b1, n);
    chk_n(n, 1, "delay floor");
    @(posedge i_clk) first_set <= 16'h0005;
    wait_for(5, 1'b0, n);
    wait_for(5, 1'b1, n);
    wait_for(4, 1'b1, n);
    chk_n(n, 1, "setting held");
    wait_for(3, 1'b0, n);
    wait_for(3, 1'b1, n);
    wait_for(2, 1'b1, a);
    wait_for(3, 1'b1, n);
    chk_n(a + n, 2 * OSC, "low repeat");
    $display("test floor done");
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_enable = 1'b0;
    i_ramp_above = 1'b0;
    first_set = 16'h0002;
    second_set = 16'h0003;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge i_clk);
    #1;
    chk_v(mon, 6'h3f, 6'h00, "reset");
    @(posedge i_clk) i_rst_n <= 1'b1;
    @(posedge i_clk) i_enable <= 1'b1;
    t_low();
    t_high();
    t_clock();
    t_floor();
    chk_v({5'h00, shoot}, 6'h01, 6'h00, "overlap");
    close_out();
  end
endmodule
`default_nettype wire
